// ===== rtl/ajh_defines.svh
// ajh_defines.svh: constants of the jog command handler.
// assumes inclusion by bare name; definitions only.
//
// Function
// RL1: in following-error mode only mode 4 with stop high aborts.
// RL2: any other request in following-error mode is flagged illegal.
// RL3: a static stop level blocks start, forward, backward and enter.
// RL4: in jog modes 1 to 3 forward and backward act as jog controls.
// RL5: jog starts on a rising direction edge and stops on its fall.
// RL6: in a jog mode stop may be passed to the axis at any time.
// RL7: rising forward and backward in one cycle send a stop instead.
// RL8: the user program keeps the mode until the movement ends.
// RL9: stop has top priority and is taken in every mode.
// RL10: binary output gives each value as a 32-bit double word.
// RL11: bcd output gives each value as seven signed bcd digits.
// RL12: bcd sign sits in bits 31..28, decades fill bits 27..0.
// RL13: 16-bit variant: high word sign plus top three decades.
`ifndef AJH_DEFINES_SVH
`define AJH_DEFINES_SVH

// ****************************************************
// modes
// ****************************************************
`define AJH_MODE_JOG_LO 8'h01
`define AJH_MODE_JOG_HI 8'h03
`define AJH_MODE_FOLLOW 8'h04

// ****************************************************
// error byte and interrupt bits
// ****************************************************
`define AJH_ERR_ILLEGAL 5
`define AJH_IRQ_JOB 0
`define AJH_IRQ_ILLEGAL 1
`define AJH_IRQ_RANGE 2
`define AJH_IRQ_W 3

// ****************************************************
// register map, plain port
// ****************************************************
`define AJH_OFF_CTRL 4'h0
`define AJH_OFF_STATUS 4'h1
`define AJH_OFF_IRQ_STAT 4'h2
`define AJH_OFF_IRQ_MASK 4'h3
`define AJH_OFF_ERR 4'h4
`define AJH_CTRL_BCD 0
`define AJH_CTRL_MON_EN 1
`define AJH_CTRL_RST 2'h2

// ****************************************************
// bcd format
// ****************************************************
`define AJH_BCD_MAX 32'h0098967F
`define AJH_SIGN_NEG 4'hF
`define AJH_SIGN_POS 4'h0
`define AJH_BCD_DIGITS 7
`define AJH_BCD_BITS 24

`endif

// ===== rtl/ajh_pkg.sv
// ajh_pkg.sv: types of the jog command handler.
// assumes nothing beyond a SystemVerilog compiler.
package ajh_pkg;

    // jobs sent to the positioning module
    typedef enum logic [2:0] {
        JOB_NONE    = 3'b000,
        JOB_START   = 3'b001,
        JOB_STOP    = 3'b010,
        JOB_FWD     = 3'b011,
        JOB_BWD     = 3'b100,
        JOB_ENTER   = 3'b101,
        JOB_JOG_FWD = 3'b110,
        JOB_JOG_BWD = 3'b111
    } ajh_job_t;

    // handler states
    typedef enum logic [1:0] {
        ST_IDLE       = 2'b00,
        ST_JOG_FWD    = 2'b01,
        ST_JOG_BWD    = 2'b10,
        ST_FOLLOW_ERR = 2'b11
    } ajh_state_t;

endpackage : ajh_pkg

// ===== rtl/ajh_bcd_fmt.sv
// ajh_bcd_fmt.sv: signed binary to seven-digit bcd, combinational.
// assumes a 32-bit two's complement value at its input.
`timescale 1ns/1ns
`default_nettype none
`include "ajh_defines.svh"

module ajh_bcd_fmt
    import ajh_pkg::*;
(
    // binary in
    input wire logic [31:0] value,
    // bcd out
    output logic [31:0] bcd_word,
    output logic out_of_range
);

    logic [31:0] mag;
    logic [27:0] digits;

    // add three to a decade of five or more before the shift
    function automatic logic [3:0] dabble(input logic [3:0] d);
        return (d >= 4'h5) ? d + 4'h3 : d;
    endfunction : dabble

    // magnitude; the most negative value stays large and overflows
    assign mag = value[31] ? (~value + 32'h00000001) : value;
    assign out_of_range = mag > `AJH_BCD_MAX;

    // shift-add conversion over the low 24 bits, enough for 9999999
    always_comb begin
        digits = 28'h0000000;
        for (int i = `AJH_BCD_BITS - 1; i >= 0; i--) begin
            for (int d = 0; d < `AJH_BCD_DIGITS; d++) begin
                digits[4*d +: 4] = dabble(digits[4*d +: 4]);
            end
            digits = {digits[26:0], mag[i]};
        end
    end

    // sign nibble on top, decades below [RL12]
    assign bcd_word = {value[31] ? `AJH_SIGN_NEG : `AJH_SIGN_POS,
                       digits};

endmodule : ajh_bcd_fmt
`default_nettype wire

// ===== rtl/ajh_cmd_handler.sv
// ajh_cmd_handler.sv: cyclic command handler in front of an axis.
// assumes one clock cycle per scan and synchronous command levels.
//
// Design decisions made here: the address-and-strobe port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "ajh_defines.svh"

module ajh_cmd_handler
    import ajh_pkg::*;
#(
    parameter int MODE_W = 8
)
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // user program commands
    input wire logic [MODE_W-1:0] mode_sel,
    input wire logic stop_cmd,
    input wire logic motion_launch_cmd,
    input wire logic jog_forward_cmd,
    input wire logic jog_backward_cmd,
    input wire logic accept_value_cmd,
    // jobs to the positioning module
    output logic job_valid,
    output ajh_job_t job_cmd,
    output logic [MODE_W-1:0] job_mode,
    // error reporting
    output logic param_error_flag,
    output logic [7:0] error_flags,
    // monitoring values
    input wire logic [31:0] monitor_value,
    input wire logic monitor_valid,
    output logic [31:0] monitor_output_word,
    output logic [15:0] monitor_output_high,
    output logic [15:0] monitor_output_low,
    // interrupt
    output logic irq
);

    // ****************************************************
    // declarations
    // ****************************************************
    logic [4:0] prev_reg;
    logic stop_rise;
    logic fwd_rise;
    logic fwd_fall;
    logic bwd_rise;
    logic bwd_fall;
    logic launch_rise;
    logic accept_rise;
    logic jog_mode;
    logic fe_mode_sel;
    logic any_req;
    ajh_state_t state_reg;
    ajh_state_t state_next;
    ajh_job_t job_next;
    logic illegal_next;
    logic [1:0] ctrl_reg;
    logic [`AJH_IRQ_W-1:0] irq_stat_reg;
    logic [`AJH_IRQ_W-1:0] irq_mask_reg;
    logic [`AJH_IRQ_W-1:0] irq_set;
    logic [7:0] err_reg;
    logic [31:0] bcd_word;
    logic bcd_ovf;
    logic mon_take;
    logic [31:0] rd_next;

    // ****************************************************
    // edge detection of command levels
    // ****************************************************
    // one sample per scan; edges are seen whatever the mode or state
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            prev_reg <= 5'h00;
        end else begin
            prev_reg <= {accept_value_cmd, motion_launch_cmd,
                         jog_backward_cmd, jog_forward_cmd, stop_cmd};
        end
    end

    assign stop_rise = stop_cmd & ~prev_reg[0];
    assign fwd_rise = jog_forward_cmd & ~prev_reg[1];
    assign fwd_fall = ~jog_forward_cmd & prev_reg[1];
    assign bwd_rise = jog_backward_cmd & ~prev_reg[2];
    assign bwd_fall = ~jog_backward_cmd & prev_reg[2];
    assign launch_rise = motion_launch_cmd & ~prev_reg[3];
    assign accept_rise = accept_value_cmd & ~prev_reg[4];

    // mode decode
    assign jog_mode = (mode_sel >= MODE_W'(`AJH_MODE_JOG_LO)) &&
                      (mode_sel <= MODE_W'(`AJH_MODE_JOG_HI)); // [RL4]
    assign fe_mode_sel = mode_sel == MODE_W'(`AJH_MODE_FOLLOW);
    assign any_req = stop_rise | fwd_rise | bwd_rise |
                     launch_rise | accept_rise;

    // ****************************************************
    // job decision
    // ****************************************************
    // stop outranks all else; the follow state only leaves by abort
    always_comb begin
        state_next = state_reg;
        job_next = JOB_NONE;
        illegal_next = 1'b0;
        case (state_reg)
            ST_FOLLOW_ERR: begin
                if (stop_cmd && fe_mode_sel) begin
                    job_next = JOB_STOP; // [RL1]
                    state_next = ST_IDLE;
                end else if (any_req) begin
                    illegal_next = 1'b1; // [RL2]
                end
            end
            ST_IDLE, ST_JOG_FWD, ST_JOG_BWD: begin
                if (stop_rise) begin
                    job_next = JOB_STOP; // [RL9] [RL6]
                    state_next = ST_IDLE;
                end else if (stop_cmd) begin
                    job_next = JOB_NONE; // [RL3]
                end else if (fwd_rise && bwd_rise) begin
                    job_next = JOB_STOP; // [RL7]
                    state_next = ST_IDLE;
                end else if (jog_mode) begin
                    if (fwd_rise) begin
                        job_next = JOB_JOG_FWD; // [RL5]
                        state_next = ST_JOG_FWD;
                    end else if (bwd_rise) begin
                        job_next = JOB_JOG_BWD; // [RL5]
                        state_next = ST_JOG_BWD;
                    end else if (state_reg == ST_JOG_FWD && fwd_fall) begin
                        job_next = JOB_STOP; // [RL5]
                        state_next = ST_IDLE;
                    end else if (state_reg == ST_JOG_BWD && bwd_fall) begin
                        job_next = JOB_STOP; // [RL5]
                        state_next = ST_IDLE;
                    end
                end else if (launch_rise) begin
                    job_next = JOB_START;
                    state_next = fe_mode_sel ? ST_FOLLOW_ERR : ST_IDLE;
                end else if (fwd_rise) begin
                    job_next = JOB_FWD; // one-shot outside jog [RL4]
                end else if (bwd_rise) begin
                    job_next = JOB_BWD; // [RL4]
                end else if (accept_rise) begin
                    job_next = JOB_ENTER;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // job output; command and mode hold until the next job
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            job_valid <= 1'b0;
            job_cmd <= JOB_NONE;
            job_mode <= '0;
        end else begin
            job_valid <= job_next != JOB_NONE;
            if (job_next != JOB_NONE) begin
                job_cmd <= job_next;
                job_mode <= mode_sel;
            end
        end
    end

    // ****************************************************
    // error byte, cleared by writing ones, set wins
    // ****************************************************
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            err_reg <= 8'h00;
        end else begin
            for (int i = 0; i < 8; i++) begin
                if (illegal_next && i == `AJH_ERR_ILLEGAL) begin
                    err_reg[i] <= 1'b1; // [RL2]
                end else if (reg_wr && reg_addr == `AJH_OFF_ERR &&
                             reg_wdata[i]) begin
                    err_reg[i] <= 1'b0;
                end
            end
        end
    end

    assign error_flags = err_reg;
    assign param_error_flag = |err_reg; // [RL2]

    // ****************************************************
    // monitoring output
    // ****************************************************
    ajh_bcd_fmt u_bcd (
        .value(monitor_value),
        .bcd_word(bcd_word),
        .out_of_range(bcd_ovf)
    );

    assign mon_take = monitor_valid & ctrl_reg[`AJH_CTRL_MON_EN];

    // an unconvertible value leaves the previous output in place
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            monitor_output_word <= 32'h00000000;
            monitor_output_high <= 16'h0000;
            monitor_output_low <= 16'h0000;
        end else if (mon_take) begin
            if (!ctrl_reg[`AJH_CTRL_BCD]) begin
                monitor_output_word <= monitor_value; // [RL10]
                monitor_output_high <= monitor_value[31:16];
                monitor_output_low <= monitor_value[15:0];
            end else if (!bcd_ovf) begin
                monitor_output_word <= bcd_word; // [RL11] [RL12]
                monitor_output_high <= bcd_word[31:16]; // [RL13]
                monitor_output_low <= bcd_word[15:0]; // [RL13]
            end
        end
    end

    // ****************************************************
    // control register
    // ****************************************************
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ctrl_reg <= `AJH_CTRL_RST;
        end else if (reg_wr && reg_addr == `AJH_OFF_CTRL) begin
            ctrl_reg <= reg_wdata[1:0];
        end
    end

    // ****************************************************
    // interrupts
    // ****************************************************
    assign irq_set[`AJH_IRQ_JOB] = job_next != JOB_NONE;
    assign irq_set[`AJH_IRQ_ILLEGAL] = illegal_next;
    assign irq_set[`AJH_IRQ_RANGE] = mon_take & ctrl_reg[`AJH_CTRL_BCD] &
                                     bcd_ovf;

    // sticky bits; a new event beats a clear in the same cycle
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irq_stat_reg <= '0;
        end else if (reg_wr && reg_addr == `AJH_OFF_IRQ_STAT) begin
            irq_stat_reg <= (irq_stat_reg & ~reg_wdata[`AJH_IRQ_W-1:0])
                            | irq_set;
        end else begin
            irq_stat_reg <= irq_stat_reg | irq_set;
        end
    end

    // mask register
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irq_mask_reg <= '0;
        end else if (reg_wr && reg_addr == `AJH_OFF_IRQ_MASK) begin
            irq_mask_reg <= reg_wdata[`AJH_IRQ_W-1:0];
        end
    end

    assign irq = |(irq_stat_reg & irq_mask_reg);

    // ****************************************************
    // read port
    // ****************************************************
    // unmapped reads answer zero
    always_comb begin
        case (reg_addr)
            `AJH_OFF_CTRL: rd_next = {30'h00000000, ctrl_reg};
            `AJH_OFF_STATUS: rd_next = {27'h0000000, job_cmd, state_reg};
            `AJH_OFF_IRQ_STAT: rd_next = {29'h00000000, irq_stat_reg};
            `AJH_OFF_IRQ_MASK: rd_next = {29'h00000000, irq_mask_reg};
            `AJH_OFF_ERR: rd_next = {24'h000000, err_reg};
            default: rd_next = 32'h00000000;
        endcase
    end

    // data stand only in the cycle after the strobe
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            reg_rdata <= 32'h00000000;
        end else begin
            reg_rdata <= reg_rd ? rd_next : 32'h00000000;
        end
    end

    // ****************************************************
    // checks
    // ****************************************************
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    sequence s_fwd_rise;
        !jog_forward_cmd ##1 jog_forward_cmd;
    endsequence

    sequence s_fwd_fall;
        jog_forward_cmd ##1 !jog_forward_cmd;
    endsequence

    sequence s_stop_rise;
        !stop_cmd ##1 stop_cmd;
    endsequence

    property p_fe_abort;
        (state_reg == ST_FOLLOW_ERR && stop_cmd && fe_mode_sel)
        |=> job_valid && job_cmd == JOB_STOP && state_reg == ST_IDLE;
    endproperty
    a_fe_abort: assert property (p_fe_abort) // [RL1]
        else $error("follow abort did not send stop");

    property p_fe_illegal;
        (state_reg == ST_FOLLOW_ERR && !(stop_cmd && fe_mode_sel)
         && any_req)
        |=> !job_valid && error_flags[`AJH_ERR_ILLEGAL]
            && param_error_flag && state_reg == ST_FOLLOW_ERR;
    endproperty
    a_fe_illegal: assert property (p_fe_illegal) // [RL2]
        else $error("illegal request in follow mode not flagged");

    property p_static_stop;
        stop_cmd ##1 stop_cmd |-> ##1 (!job_valid ||
                                       job_cmd == JOB_STOP);
    endproperty
    a_static_stop: assert property (p_static_stop) // [RL3]
        else $error("job sent while stop held");

    property p_jog_start;
        s_fwd_rise ##0 (jog_mode && !stop_cmd && !bwd_rise
                        && state_reg != ST_FOLLOW_ERR)
        |=> job_valid && job_cmd == JOB_JOG_FWD
            && state_reg == ST_JOG_FWD;
    endproperty
    a_jog_start: assert property (p_jog_start) // [RL5]
        else $error("jog forward not started on rising edge");

    property p_jog_halt;
        s_fwd_fall ##0 (state_reg == ST_JOG_FWD && jog_mode
                        && !stop_cmd && !bwd_rise)
        |=> job_valid && job_cmd == JOB_STOP && state_reg == ST_IDLE;
    endproperty
    a_jog_halt: assert property (p_jog_halt) // [RL5]
        else $error("jog forward not stopped on falling edge");

    property p_both_rise;
        (!jog_forward_cmd && !jog_backward_cmd) ##1
        (jog_forward_cmd && jog_backward_cmd && !stop_cmd
         && state_reg != ST_FOLLOW_ERR)
        |=> job_valid && job_cmd == JOB_STOP;
    endproperty
    a_both_rise: assert property (p_both_rise) // [RL7]
        else $error("simultaneous edges did not send stop");

    property p_stop_first;
        s_stop_rise ##0 (state_reg != ST_FOLLOW_ERR)
        |=> job_valid && job_cmd == JOB_STOP && state_reg == ST_IDLE;
    endproperty
    a_stop_first: assert property (p_stop_first) // [RL9]
        else $error("stop edge not sent first");

    property p_bin_out;
        (mon_take && !ctrl_reg[`AJH_CTRL_BCD])
        |=> monitor_output_word == $past(monitor_value)
            && monitor_output_high == monitor_output_word[31:16];
    endproperty
    a_bin_out: assert property (p_bin_out) // [RL10]
        else $error("binary monitor value not passed");

    property p_bcd_hold;
        (mon_take && ctrl_reg[`AJH_CTRL_BCD] && bcd_ovf)
        |=> $stable(monitor_output_word)
            && irq_stat_reg[`AJH_IRQ_RANGE];
    endproperty
    a_bcd_hold: assert property (p_bcd_hold) // [RL11]
        else $error("out of range bcd value changed output");

    property p_bcd_sign;
        (mon_take && ctrl_reg[`AJH_CTRL_BCD] && !bcd_ovf
         && monitor_value[31])
        |=> monitor_output_word[31:28] == `AJH_SIGN_NEG
            && monitor_output_high[15:12] == `AJH_SIGN_NEG;
    endproperty
    a_bcd_sign: assert property (p_bcd_sign) // [RL12]
        else $error("negative bcd sign nibble wrong");

    property p_bcd_split;
        (mon_take && ctrl_reg[`AJH_CTRL_BCD] && !bcd_ovf)
        |=> {monitor_output_high, monitor_output_low}
            == monitor_output_word;
    endproperty
    a_bcd_split: assert property (p_bcd_split) // [RL13]
        else $error("bcd word halves do not match");

endmodule : ajh_cmd_handler
`default_nettype wire

// ===== verif/ajh_axis_model.sv
// ajh_axis_model.sv: behavioural stand-in for the positioning module.
// assumes jobs arrive as one-cycle pulses on the handler's clock.
`timescale 1ns/1ns
`default_nettype none

module ajh_axis_model
    import ajh_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // jobs from the handler
    input wire logic job_valid,
    input wire ajh_job_t job_cmd,
    input wire logic [7:0] job_mode,
    // job log for the bench
    output logic [15:0] job_count,
    output ajh_job_t last_job,
    output logic moving
);
    // ****************************************************
    // job log
    // ****************************************************
    // count every pulse so that a missing or extra job shows up
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            job_count <= 16'h0000;
            last_job <= JOB_NONE;
        end else if (job_valid) begin
            job_count <= job_count + 16'h0001;
            last_job <= job_cmd;
        end
    end

    // axis runs after any motion job, halts on a stop
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            moving <= 1'b0;
        end else if (job_valid) begin
            moving <= (job_cmd != JOB_STOP) && (job_cmd != JOB_ENTER);
        end
    end
endmodule : ajh_axis_model

`default_nettype wire

// ===== verif/axis_jog_command_handler_tb_top.sv
// axis_jog_command_handler_tb_top.sv: self-checking bench of the handler.
// assumes the handler's assertions live in its own files.
`timescale 1ns/1ns
`default_nettype none
`include "ajh_defines.svh"

module axis_jog_command_handler_tb_top
    import ajh_pkg::*;
;
    // ****************************************************
    // signals
    // ****************************************************
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic [7:0] mode_sel = 8'h00;
    logic stop = 1'b0;
    logic launch = 1'b0;
    logic fwd = 1'b0;
    logic bwd = 1'b0;
    logic enter = 1'b0;
    logic job_valid;
    ajh_job_t job_cmd;
    logic [7:0] job_mode;
    logic param_error_flag;
    logic [7:0] error_flags;
    logic [31:0] monitor_value = 32'h0;
    logic monitor_valid = 1'b0;
    logic [31:0] mon_word;
    logic [15:0] mon_hi;
    logic [15:0] mon_lo;
    logic irq;
    logic [15:0] jobs;
    ajh_job_t last;
    logic [15:0] base;
    logic [31:0] rdv;
    int n_errors = 0;
    int n_tests = 0;

    // 100 MHz system clock
    always #5 clk_sys = ~clk_sys;

    ajh_cmd_handler #(.MODE_W(8)) dut_u (
        .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .mode_sel(mode_sel), .stop_cmd(stop),
        .motion_launch_cmd(launch), .jog_forward_cmd(fwd),
        .jog_backward_cmd(bwd), .accept_value_cmd(enter),
        .job_valid(job_valid), .job_cmd(job_cmd), .job_mode(job_mode),
        .param_error_flag(param_error_flag), .error_flags(error_flags),
        .monitor_value(monitor_value), .monitor_valid(monitor_valid),
        .monitor_output_word(mon_word), .monitor_output_high(mon_hi),
        .monitor_output_low(mon_lo), .irq(irq));

    ajh_axis_model axis_u (
        .clk_sys(clk_sys), .rst(rst), .job_valid(job_valid),
        .job_cmd(job_cmd), .job_mode(job_mode), .job_count(jobs),
        .last_job(last), .moving());

    // ****************************************************
    // helpers
    // ****************************************************
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task test_done();
        if (n_errors == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : test_done

    // let an edge reach the axis
    task settle();
        repeat (3) @(posedge clk_sys);
        #1;
    endtask : settle

    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr

    // data stand one cycle after the strobe
    task rd(input logic [3:0] a);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        rdv = reg_rdata;
    endtask : rd

    task job_chk(input ajh_job_t j, input logic [15:0] n);
        chk({16'h0, jobs - base}, {16'h0, n});
        chk({29'h0, last}, {29'h0, j});
        chk({24'h0, job_mode}, {24'h0, mode_sel});
    endtask : job_chk

    task mon(input logic [31:0] v);
        @(posedge clk_sys);
        monitor_value <= v;
        monitor_valid <= 1'b1;
        @(posedge clk_sys);
        monitor_valid <= 1'b0;
        settle();
    endtask : mon

    // ****************************************************
    // scenarios
    // ****************************************************
    task t_regs();
        rd(`AJH_OFF_CTRL);
        chk(rdv, 32'h00000002);
        rd(4'hF);
        chk(rdv, 32'h00000000);
        chk({31'h0, irq}, 32'h0);
    endtask : t_regs

    // the user program holds the mode through each movement
    task t_jog();
        @(posedge clk_sys);
        mode_sel <= `AJH_MODE_JOG_LO;
        settle();
        base = jobs;
        @(posedge clk_sys);
        fwd <= 1'b1;
        settle();
        job_chk(JOB_JOG_FWD, 16'h1);
        rd(`AJH_OFF_STATUS);
        chk({30'h0, rdv[1:0]}, 32'h1);
        @(posedge clk_sys);
        fwd <= 1'b0;
        settle();
        job_chk(JOB_STOP, 16'h2);
        @(posedge clk_sys);
        mode_sel <= `AJH_MODE_JOG_HI;
        bwd <= 1'b1;
        settle();
        job_chk(JOB_JOG_BWD, 16'h3);
        @(posedge clk_sys);
        stop <= 1'b1;
        settle();
        job_chk(JOB_STOP, 16'h4);
        @(posedge clk_sys);
        bwd <= 1'b0;
        settle();
        @(posedge clk_sys);
        stop <= 1'b0;
        settle();
    endtask : t_jog

    task t_both();
        @(posedge clk_sys);
        mode_sel <= 8'h02;
        settle();
        base = jobs;
        @(posedge clk_sys);
        fwd <= 1'b1;
        bwd <= 1'b1;
        settle();
        job_chk(JOB_STOP, 16'h1);
        @(posedge clk_sys);
        fwd <= 1'b0;
        bwd <= 1'b0;
        settle();
    endtask : t_both

    // a held stop swallows every launching edge
    task t_stop_level();
        @(posedge clk_sys);
        mode_sel <= 8'h05;
        settle();
        base = jobs;
        @(posedge clk_sys);
        stop <= 1'b1;
        settle();
        job_chk(JOB_STOP, 16'h1);
        @(posedge clk_sys);
        {launch, fwd, bwd, enter} <= 4'hF;
        settle();
        job_chk(JOB_STOP, 16'h1);
        @(posedge clk_sys);
        {launch, fwd, bwd, enter} <= 4'h0;
        settle();
        @(posedge clk_sys);
        {stop, enter} <= 2'b01;
        settle();
        job_chk(JOB_ENTER, 16'h2);
    endtask : t_stop_level

    task t_follow();
        wr(`AJH_OFF_IRQ_STAT, 32'h7);
        wr(`AJH_OFF_IRQ_MASK, 32'h2);
        @(posedge clk_sys);
        mode_sel <= `AJH_MODE_FOLLOW;
        settle();
        base = jobs;
        @(posedge clk_sys);
        launch <= 1'b1;
        settle();
        job_chk(JOB_START, 16'h1);
        rd(`AJH_OFF_STATUS);
        chk({30'h0, rdv[1:0]}, 32'h3);
        @(posedge clk_sys);
        fwd <= 1'b1;
        settle();
        chk({16'h0, jobs - base}, 32'h1);
        chk({31'h0, error_flags[`AJH_ERR_ILLEGAL]}, 32'h1);
        chk({31'h0, param_error_flag}, 32'h1);
        chk({31'h0, irq}, 32'h1);
        @(posedge clk_sys);
        {launch, fwd} <= 2'b00;
        stop <= 1'b1;
        settle();
        job_chk(JOB_STOP, 16'h2);
        rd(`AJH_OFF_STATUS);
        chk({30'h0, rdv[1:0]}, 32'h0);
        @(posedge clk_sys);
        stop <= 1'b0;
        wr(`AJH_OFF_ERR, 32'hFF);
        wr(`AJH_OFF_IRQ_STAT, 32'h7);
        settle();
        chk({31'h0, param_error_flag}, 32'h0);
        chk({31'h0, irq}, 32'h0);
    endtask : t_follow

    task t_mon();
        mon(32'hFFFFFFFB);
        chk(mon_word, 32'hFFFFFFFB);
        wr(`AJH_OFF_CTRL, 32'h3);
        wr(`AJH_OFF_IRQ_MASK, 32'h4);
        mon(32'hFFFFFF85);
        chk(mon_word, 32'hF0000123);
        chk({16'h0, mon_hi}, 32'h0000F000);
        chk({16'h0, mon_lo}, 32'h00000123);
        mon(32'h0098967F);
        chk(mon_word, 32'h09999999);
        mon(32'h00989680);
        chk(mon_word, 32'h09999999);
        chk({31'h0, irq}, 32'h1);
        wr(`AJH_OFF_IRQ_STAT, 32'h4);
        settle();
        chk({31'h0, irq}, 32'h0);
    endtask : t_mon

    // ****************************************************
    // main sequence and watchdog
    // ****************************************************
    initial begin
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        settle();
        t_regs();
        t_jog();
        t_both();
        t_stop_level();
        t_follow();
        t_mon();
        test_done();
    end

    // run takes under 1000 cycles
    initial begin
        #50000;
        n_errors++;
        test_done();
    end
endmodule : axis_jog_command_handler_tb_top

`default_nettype wire
